// *** verilog/pfbs_pkg.sv ***
// package of constants and types for the capacitor bank power factor stepper
// ---------------------------------------------------------------------------
// Notes on behaviour
// RULE1 - measured factor, voltage and current are taken on each 5 ms period strobe
// RULE2 - default factor source is phase two-three voltage with phase two current
// RULE3 - current source select: 0 three-phase inputs, 1 phase two only
// RULE4 - bank count setting 1 to 5; only those banks switch
// RULE5 - control type: 0 voltage level, 1 power factor sensitivity
// RULE6 - mode: 0 manual level by hand, 1 automatic (default)
// RULE7 - each bank rating 0 to 500.0 kvar, in 0.1 kvar units
// RULE8 - maximum kvar is sum of ratings of banks in use
// RULE9 - connected kvar is sum of ratings of closed breakers
// RULE10 - each bank condition is off or active from breaker status
// RULE11 - bank n drives switching object n
// RULE12 - set point 0.70 to 0.99 in 0.01 steps, default 0.95
// RULE13 - below set point add capacitance if inductive, remove if capacitive
// RULE14 - no hysteresis; only the discharge delay limits switching
// RULE15 - automatic stepping is inhibited while the discharge delay runs
// RULE16 - discharge delay set in 0.1 s units, default 300.0 s
// RULE17 - block input is sampled at the start of each program cycle
// RULE18 - pickup while not blocked asserts start and evaluates delay
// RULE19 - pickup while blocked asserts blocked and stops processing
// RULE20 - blocking an active start clears start as a normal reset
// RULE21 - blocking activation issues display and time-stamped blocking events
// RULE22 - block source must assert at least 5 ms before delay expires
// RULE23 - discharge delay is enforced between every step, up or down
// RULE24 - events on increase, decrease, discharge, automatic and block changes
// RULE25 - a bank rated zero is skipped by the stepping
// RULE26 - automatic mode moves one adjacent level per discharge interval
// ---------------------------------------------------------------------------
package pfbs_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TENTH_S_MS    = 100;
  localparam int unsigned TENTH_S_CYC   = CLK_HZ / 1000 * TENTH_S_MS;
  localparam int unsigned PERIOD_MS     = 5;
  localparam int unsigned PERIOD_CYC    = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned NBANK         = 5;
  localparam int unsigned KV_W          = 13;
  localparam int unsigned SUM_W         = 16;
  localparam int unsigned NCOMB         = 32;
  localparam logic [12:0] KV_MAX        = 13'h1388;
  localparam logic [6:0]  SP_MIN        = 7'h46;
  localparam logic [6:0]  SP_MAX        = 7'h63;
  localparam logic [6:0]  SP_DEF        = 7'h5f;
  localparam logic [14:0] DIS_DEF       = 15'h0bb8;
  localparam logic [2:0]  BANKS_MIN     = 3'h1;
  localparam logic [2:0]  BANKS_MAX     = 3'h5;
  localparam logic        SRC_THREE     = 1'b0;
  localparam logic        CTL_SENS      = 1'b1;
  localparam logic        MODE_AUTO     = 1'b1;

  typedef enum logic [2:0] {
    PF_IDLE  = 3'b001,
    PF_START = 3'b010,
    PF_BLOCK = 3'b100
  } pfbs_state_t;
endpackage : pfbs_pkg

// *** verilog/pfbs_comb_sum.sv ***
// combinational kvar sum of a bank combination
`timescale 1ns/1ns
module pfbs_comb_sum
  import pfbs_pkg::*;
(
  // bank pattern and ratings
  input  wire logic [NBANK-1:0]           sel,
  input  wire logic [NBANK-1:0][KV_W-1:0] rating,
  // result
  output logic      [SUM_W-1:0]           total
);
  always_comb begin
    total = '0;
    for (int i = 0; i < NBANK; i++) begin
      if (sel[i]) begin
        total = total + SUM_W'(rating[i]);
      end
    end
  end
endmodule : pfbs_comb_sum

// *** verilog/pfbs_stepper.sv ***
// capacitor bank stepper: picks one adjacent kvar step per discharge interval
`timescale 1ns/1ns
module pfbs_stepper
  import pfbs_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // measurement front end, one strobe per period
  input  wire logic                       meas_strobe,
  input  wire logic [6:0]                 measured_power_factor,
  input  wire logic                       factor_capacitive,
  input  wire logic [15:0]                line_voltage_phase2_phase3,
  input  wire logic [15:0]                phase_two_current,
  input  wire logic [15:0]                phase_current_three,
  input  wire logic [15:0]                voltage_low_limit,
  input  wire logic [15:0]                voltage_high_limit,
  // configuration
  input  wire logic                       current_source_sel,
  input  wire logic [2:0]                 banks_in_use,
  input  wire logic                       control_type,
  input  wire logic                       control_mode,
  input  wire logic [NBANK-1:0][KV_W-1:0] bank_rating,
  input  wire logic [6:0]                 target_factor_setpoint,
  input  wire logic [14:0]                discharge_tenths,
  input  wire logic [NBANK-1:0]           manual_pattern,
  input  wire logic                       block_in,
  // breaker objects
  input  wire logic [NBANK-1:0]           breaker_closed,
  output logic      [NBANK-1:0]           object_close_cmd,
  output logic      [NBANK-1:0]           object_open_cmd,
  // status
  output logic      [SUM_W-1:0]           max_kvar,
  output logic      [SUM_W-1:0]           connected_kvar,
  output logic      [NBANK-1:0]           bank_active,
  output logic                            start_out,
  output logic                            blocked_out,
  output logic                            increase_req,
  output logic                            decrease_req,
  output logic                            discharge_active,
  output logic                            auto_active,
  output logic      [15:0]                meas_voltage,
  output logic      [15:0]                meas_current,
  output logic      [6:0]                 meas_factor,
  // events: one-cycle pulses, with current and fault held from the last block event
  output logic                            block_event,
  output logic                            display_event,
  output logic      [15:0]                block_evt_current,
  output logic      [1:0]                 block_evt_fault,
  output logic      [9:0]                 status_event
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pfbs_state_t      st;
    logic             blk;
    logic [15:0]      volt;
    logic [15:0]      cur;
    logic [6:0]       pf;
    logic             cap;
    logic             fresh;
    logic [NBANK-1:0] cls;
    logic [NBANK-1:0] opn;
    logic [19:0]      tick;
    logic [14:0]      dis;
    logic [SUM_W-1:0] maxk;
    logic [SUM_W-1:0] conk;
    logic [NBANK-1:0] act;
    logic             inc;
    logic             dec;
    logic             auto_m;
    logic             bev;
    logic             dev;
    logic [15:0]      bcur;
    logic [1:0]       bflt;
    logic [9:0]       sev;
    // decoded levels kept in flops so every output is registered
    logic             strt;
    logic             blko;
    logic             disa;
  } pfbs_reg_t;

  pfbs_reg_t r_q;
  pfbs_reg_t r_d;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [NBANK-1:0] use_mask(input logic [2:0] n);
    logic [NBANK-1:0] m;
    m = '0;
    for (int i = 0; i < NBANK; i++) begin
      if (3'(i) < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : use_mask

  function automatic logic [SUM_W-1:0] kv_sum(input logic [NBANK-1:0] s,
                                              input logic [NBANK-1:0][KV_W-1:0] rt);
    logic [SUM_W-1:0] t;
    t = '0;
    for (int i = 0; i < NBANK; i++) begin
      if (s[i]) begin
        t = t + SUM_W'(rt[i]);
      end
    end
    return t;
  endfunction : kv_sum

  logic [2:0]             nb;
  logic [NBANK-1:0]       mask;
  logic [NBANK-1:0][KV_W-1:0] rate_c;
  logic [SUM_W-1:0]       conk_now;
  logic                   pickup;
  logic                   want_up;
  logic                   want_dn;
  logic [NBANK-1:0]       best;
  logic [SUM_W-1:0]       best_kv;
  logic                   found;
  logic [SUM_W-1:0]       cand_kv;
  logic [NBANK-1:0]       cur_pat;

  always_comb begin
    nb = banks_in_use;
    if (nb < BANKS_MIN) begin
      nb = BANKS_MIN;
    end
    if (nb > BANKS_MAX) begin
      nb = BANKS_MAX;
    end
  end

  assign mask = use_mask(nb);                                 // RULE4
  assign cur_pat = breaker_closed & mask;

  // ratings clamped to the 500.0 kvar ceiling
  always_comb begin
    for (int i = 0; i < NBANK; i++) begin
      rate_c[i] = (bank_rating[i] > KV_MAX) ? KV_MAX : bank_rating[i];   // RULE7
    end
  end

  pfbs_comb_sum u_conn (                                      // RULE9
    .sel    (cur_pat),
    .rating (rate_c),
    .total  (conk_now)
  );

  // pickup: voltage window or factor below set point, no hysteresis
  always_comb begin
    want_up = 1'b0;
    want_dn = 1'b0;
    if (control_type == CTL_SENS) begin                       // RULE5
      if (r_q.pf < target_factor_setpoint) begin            // RULE12 RULE14
        want_up = !r_q.cap;                                   // RULE13
        want_dn = r_q.cap;
      end
    end else begin
      want_up = r_q.volt < voltage_low_limit;
      want_dn = r_q.volt > voltage_high_limit;
    end
  end
  assign pickup = want_up | want_dn;

  // search the adjacent achievable level over every pattern of usable banks
  always_comb begin
    best    = cur_pat;
    best_kv = conk_now;
    found   = 1'b0;
    cand_kv = '0;
    for (int c = 0; c < NCOMB; c++) begin
      cand_kv = kv_sum(NBANK'(c), rate_c);
      // zero-rated banks excluded so maintenance banks stay idle
      if ((NBANK'(c) & ~mask) == '0 && !(|(NBANK'(c) & ~cur_pat & {
          rate_c[4] == '0, rate_c[3] == '0, rate_c[2] == '0,
          rate_c[1] == '0, rate_c[0] == '0}))) begin         // RULE25
        if (want_up && cand_kv > conk_now && (!found || cand_kv < best_kv)) begin
          best = NBANK'(c);                                   // RULE26
          best_kv = cand_kv;
          found = 1'b1;
        end
        if (want_dn && cand_kv < conk_now && (!found || cand_kv > best_kv)) begin
          best = NBANK'(c);                                   // RULE26
          best_kv = cand_kv;
          found = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.bev = 1'b0;
    r_d.dev = 1'b0;
    r_d.sev = '0;
    r_d.fresh = 1'b0;
    r_d.blk = block_in;                                       // RULE17
    if (meas_strobe) begin                                    // RULE1
      r_d.volt  = line_voltage_phase2_phase3;                 // RULE2
      r_d.pf    = measured_power_factor;
      r_d.cap   = factor_capacitive;
      r_d.cur   = (current_source_sel == SRC_THREE) ?
                  phase_current_three : phase_two_current;    // RULE3
      r_d.fresh = 1'b1;
    end
    r_d.maxk = kv_sum(mask, rate_c);                          // RULE8
    r_d.conk = conk_now;
    r_d.act  = cur_pat;                                       // RULE10
    r_d.auto_m = control_mode == MODE_AUTO;
    // discharge timer in tenths of a second
    if (r_q.dis != '0) begin
      if (r_q.tick == 20'(TENTH_S_CYC - 1)) begin
        r_d.tick = '0;
        r_d.dis  = r_q.dis - 15'h0001;
      end else begin
        r_d.tick = r_q.tick + 20'h00001;
      end
    end
    r_d.cls = '0;
    r_d.opn = '0;
    r_d.inc = 1'b0;
    r_d.dec = 1'b0;
    case (r_q.st)
      PF_IDLE: begin
        if (r_q.fresh && pickup) begin
          if (r_q.blk) begin                                  // RULE19
            r_d.st  = PF_BLOCK;
            r_d.bev = 1'b1;                                   // RULE21
            r_d.dev = 1'b1;
          end else begin
            r_d.st = PF_START;                                // RULE18
          end
        end
      end
      PF_START: begin
        if (r_q.blk) begin                                    // RULE20
          r_d.st  = PF_BLOCK;
          r_d.bev = 1'b1;                                     // RULE21
          r_d.dev = 1'b1;
        end else if (!pickup) begin
          r_d.st = PF_IDLE;
        end else begin
          r_d.inc = want_up;
          r_d.dec = want_dn;
          if (r_q.auto_m && r_q.dis == '0 && found) begin     // RULE15 RULE23
            r_d.cls  = best & ~cur_pat;                       // RULE11
            r_d.opn  = cur_pat & ~best;
            r_d.dis  = discharge_tenths;                      // RULE16
            r_d.tick = '0;
          end
        end
      end
      PF_BLOCK: begin
        if (!r_q.blk) begin
          r_d.st = PF_IDLE;
        end
      end
      default: begin
        r_d.st = PF_IDLE;
      end
    endcase
    // manual level set by hand, still spaced by the discharge delay
    if (!r_q.auto_m && r_q.dis == '0 && (manual_pattern & mask) != cur_pat) begin  // RULE6
      r_d.cls  = manual_pattern & mask & ~cur_pat;
      r_d.opn  = cur_pat & ~(manual_pattern & mask);
      r_d.dis  = discharge_tenths;                            // RULE23
      r_d.tick = '0;
    end
    if (r_d.bev) begin
      r_d.bcur = r_q.cur;
      r_d.bflt = {r_q.cap, control_type};
    end
    // status change events: on/off pairs
    r_d.sev = {
      (r_d.st == PF_BLOCK) && (r_q.st != PF_BLOCK), (r_d.st != PF_BLOCK) && (r_q.st == PF_BLOCK),
      r_d.auto_m & ~r_q.auto_m, ~r_d.auto_m & r_q.auto_m,
      (r_d.dis != '0) && (r_q.dis == '0), (r_d.dis == '0) && (r_q.dis != '0),
      r_d.dec & ~r_q.dec, ~r_d.dec & r_q.dec,
      r_d.inc & ~r_q.inc, ~r_d.inc & r_q.inc};                // RULE24
    r_d.strt = r_d.st == PF_START;                            // RULE18
    r_d.blko = r_d.st == PF_BLOCK;                            // RULE19
    r_d.disa = r_d.dis != '0;                                 // RULE15
    if (rst) begin
      r_d = '0;
      r_d.st = PF_IDLE;
      r_d.auto_m = MODE_AUTO;
    end
  end

  always_ff @(posedge core_clk) begin
    r_q <= r_d;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign object_close_cmd  = r_q.cls;
  assign object_open_cmd   = r_q.opn;
  assign max_kvar          = r_q.maxk;
  assign connected_kvar    = r_q.conk;
  assign bank_active       = r_q.act;
  assign start_out         = r_q.strt;
  assign blocked_out       = r_q.blko;
  assign increase_req      = r_q.inc;
  assign decrease_req      = r_q.dec;
  assign discharge_active  = r_q.disa;
  assign auto_active       = r_q.auto_m;
  assign meas_voltage      = r_q.volt;
  assign meas_current      = r_q.cur;
  assign meas_factor       = r_q.pf;
  assign block_event       = r_q.bev;
  assign display_event     = r_q.dev;
  assign block_evt_current = r_q.bcur;
  assign block_evt_fault   = r_q.bflt;
  assign status_event      = r_q.sev;
endmodule : pfbs_stepper

// *** sim/pfbs_monitor.sv ***
// concurrent checks on the bank stepper ports
`timescale 1ns/1ns
module pfbs_monitor
  import pfbs_pkg::*;
(
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // inputs
  input wire logic                       meas_strobe,
  input wire logic [6:0]                 measured_power_factor,
  input wire logic                       factor_capacitive,
  input wire logic [2:0]                 banks_in_use,
  input wire logic                       control_type,
  input wire logic                       control_mode,
  input wire logic [NBANK-1:0][KV_W-1:0] bank_rating,
  input wire logic [6:0]                 target_factor_setpoint,
  input wire logic                       block_in,
  input wire logic [NBANK-1:0]           breaker_closed,
  // outputs
  input wire logic [NBANK-1:0]           object_close_cmd,
  input wire logic [NBANK-1:0]           object_open_cmd,
  input wire logic [SUM_W-1:0]           max_kvar,
  input wire logic [SUM_W-1:0]           connected_kvar,
  input wire logic [NBANK-1:0]           bank_active,
  input wire logic                       start_out,
  input wire logic                       blocked_out,
  input wire logic                       increase_req,
  input wire logic                       decrease_req,
  input wire logic                       block_event,
  input wire logic                       display_event
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic [SUM_W-1:0] ksum(input logic [NBANK-1:0] s,
                                            input logic [NBANK-1:0][KV_W-1:0] r);
    ksum = '0;
    for (int i = 0; i < NBANK; i++) begin
      if (s[i]) ksum += SUM_W'(r[i]);
    end
  endfunction : ksum
  sequence s_blk_held;
    block_in [*4];
  endsequence
  sequence s_low_pf;
    meas_strobe && !factor_capacitive && control_type && control_mode && !block_in
    && !blocked_out && measured_power_factor < target_factor_setpoint;
  endsequence
  cmd_excl_a: assert property (!(|(object_close_cmd & object_open_cmd)))
    else $error("close and open on one object");
  conn_kvar_a: assert property (!$past(rst) |->
    connected_kvar == ksum($past(breaker_closed), $past(bank_rating)))
    else $error("connected kvar wrong");
  bank_state_a: assert property (!$past(rst) |-> bank_active == $past(breaker_closed))
    else $error("bank condition wrong");
  max_kvar_a: assert property ($stable(bank_rating) && $stable(banks_in_use)
    && !$past(rst) |-> max_kvar == ksum(NBANK'((6'h1 << banks_in_use) - 6'h1), bank_rating))
    else $error("max kvar wrong");
  blk_quiet_a: assert property (blocked_out && $past(blocked_out)
    |-> !(|(object_close_cmd | object_open_cmd))) else $error("switching while blocked");
  blk_clear_a: assert property (s_blk_held |-> !start_out)
    else $error("start kept under block");
  pickup_start_a: assert property (s_low_pf |-> ##[1:3] start_out)
    else $error("no start on pickup");
  incdec_excl_a: assert property (!(increase_req && decrease_req))
    else $error("increase and decrease together");
  blk_event_a: assert property (block_event |-> display_event)
    else $error("block event without display event");
endmodule : pfbs_monitor
bind pfbs_stepper pfbs_monitor u_mon (.*);

// *** sim/pfbs_breaker_model.sv ***
// breaker objects and measurement strobe for the bank stepper bench
`timescale 1ns/1ns
module pfbs_breaker_model
  import pfbs_pkg::*;
#(
  parameter int STROBE_CYC = 20
)(
  // clock, reset, speed
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             slow,
  // switching objects and strobe
  input  wire logic [NBANK-1:0] close_cmd,
  input  wire logic [NBANK-1:0] open_cmd,
  output logic      [NBANK-1:0] closed,
  output logic                  strobe
);
  // ------------------------------------------------------------
  // object travel and period strobe
  // ------------------------------------------------------------
  logic [NBANK-1:0] want;
  int               wait_n;
  int               scnt;
  // a short period stands in for the 5 ms base so the run stays short
  always @(posedge core_clk) begin
    strobe <= (scnt == 0);
    scnt <= (scnt + 1) % STROBE_CYC;
    want <= (want | close_cmd) & ~open_cmd;
    wait_n <= (closed == want) ? 0 : wait_n + 1;
    if (wait_n >= (slow ? 8 : 1)) begin
      closed <= want;
    end
    if (rst) begin
      {want, closed, strobe} <= '0;
      {wait_n, scnt} <= '0;
    end
  end
endmodule : pfbs_breaker_model

// *** sim/pfbs_stepper_tb_top.sv ***
// self-checking bench for the capacitor bank stepper
`timescale 1ns/1ns
module pfbs_stepper_tb_top
  import pfbs_pkg::*;
;
  // ------------------------------------------------------------
  // signals, design and partner
  // ------------------------------------------------------------
  logic core_clk, rst, meas_strobe, factor_capacitive, slow, current_source_sel;
  logic control_type, control_mode, block_in, start_out, blocked_out, increase_req;
  logic decrease_req, discharge_active, auto_active, block_event, display_event;
  logic [6:0] measured_power_factor, target_factor_setpoint, meas_factor;
  logic [15:0] line_voltage_phase2_phase3, phase_two_current, phase_current_three;
  logic [15:0] voltage_low_limit, voltage_high_limit, meas_voltage, meas_current;
  logic [15:0] block_evt_current;
  logic [SUM_W-1:0] max_kvar, connected_kvar;
  logic [NBANK-1:0] manual_pattern, breaker_closed, object_close_cmd, object_open_cmd;
  logic [NBANK-1:0] bank_active, pat;
  logic [NBANK-1:0][KV_W-1:0] bank_rating;
  logic [14:0] discharge_tenths;
  logic [2:0] banks_in_use;
  logic [1:0] block_evt_fault;
  logic [9:0] status_event;
  int err_total, cmp_count, cyc, blk_n, zb;
  pfbs_stepper uut (.*);
  pfbs_breaker_model u_brk (.core_clk(core_clk), .rst(rst), .slow(slow),
    .close_cmd(object_close_cmd), .open_cmd(object_open_cmd),
    .closed(breaker_closed), .strobe(meas_strobe));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic tick();
    @(posedge core_clk);
    #10;
  endtask : tick
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16
  function automatic logic [SUM_W-1:0] exp_sum(input logic [NBANK-1:0] s);
    exp_sum = '0;
    for (int i = 0; i < NBANK; i++) begin
      if (s[i]) exp_sum += SUM_W'(bank_rating[i]);
    end
  endfunction : exp_sum
  // banks in use that carry a nonzero rating
  function automatic logic [NBANK-1:0] full();
    full = NBANK'((6'h1 << banks_in_use) - 6'h1);
    for (int i = 0; i < NBANK; i++) begin
      if (bank_rating[i] == '0) full[i] = 1'b0;
    end
  endfunction : full
  // bounded wait for the breakers to reach a pattern, then compare
  task automatic go(input logic [NBANK-1:0] m);
    int n;
    n = 0;
    line_voltage_phase2_phase3 = 16'($urandom_range(16'h0200, 16'hfe00));
    {phase_two_current, phase_current_three} = 32'($urandom);
    // let a strobe and the registered sums catch up with new settings
    repeat (24) tick();
    while (connected_kvar !== exp_sum(m) && n < 3000) begin
      tick();
      n++;
    end
    chk16(connected_kvar, exp_sum(m), "connected");
    chk16(16'(bank_active), 16'(m), "bank state");
  endtask : go
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // hang guard, well above the few hundred cycles each round needs
  always @(posedge core_clk) begin
    cyc++;
    if (block_event === 1'b1) blk_n++;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h4515c1fa));
    {rst, slow, block_in, factor_capacitive, current_source_sel} = 5'b10000;
    {control_type, control_mode, discharge_tenths, manual_pattern} = 22'h300000;
    {voltage_low_limit, voltage_high_limit} = {16'h0100, 16'hff00};
    {line_voltage_phase2_phase3, phase_two_current, phase_current_three} = '0;
    {bank_rating, banks_in_use} = '0;
    {target_factor_setpoint, measured_power_factor} = {SP_DEF, 7'h63};
    repeat (20) tick();
    rst = 1'b0;
    tick();
    chk16(16'(auto_active), 16'h1, "auto default");
    for (int b = 1; b <= 5; b++) begin
      banks_in_use = 3'(b);
      current_source_sel = 1'($urandom_range(1));
      slow = b[0];
      zb = $urandom_range(NBANK - 1);
      for (int i = 0; i < NBANK; i++) bank_rating[i] = KV_W'($urandom_range(5000));
      bank_rating[zb] = '0;
      bank_rating[(zb + 1) % NBANK] = KV_MAX;
      target_factor_setpoint = 7'($urandom_range(70, 99));
      measured_power_factor = target_factor_setpoint - 7'($urandom_range(1, 9));
      factor_capacitive = 1'b0;
      go(full());
      chk16(max_kvar, exp_sum(NBANK'((6'h1 << b) - 6'h1)), "max kvar");
      chk16(16'(meas_factor), 16'(measured_power_factor), "factor latch");
      factor_capacitive = 1'b1;
      go('0);
    end
    control_type = 1'b0;
    factor_capacitive = 1'b0;
    repeat (200) tick();
    chk16(connected_kvar, '0, "voltage in window");
    control_type = 1'b1;
    control_mode = 1'b0;
    pat = NBANK'($urandom) & full();
    manual_pattern = pat;
    go(pat);
    chk16(16'(auto_active), 16'h0, "manual mode");
    // block raised in the same cycle as automatic mode returns, with the discharge delay set to zero
    block_in = 1'b1;
    control_mode = 1'b1;
    repeat (100) tick();
    chk16(16'(blocked_out), 16'h1, "blocked");
    chk16(16'(start_out), 16'h0, "start under block");
    chk16(16'(blk_n != 0), 16'h1, "block event");
    chk16(16'(block_evt_fault), 16'h1, "fault type");
    chk16(connected_kvar, exp_sum(pat), "held under block");
    block_in = 1'b0;
    go(full());
    give_verdict();
  end
endmodule : pfbs_stepper_tb_top
